// [dbtc_top.sv]
// dbtc_top: 16-bit timer/counter split in two byte halves with capture.
// assumes detection strobes already synchronous, one per detected event,
// and an AXI4-Lite master keeping to one write and one read at a time.
module dbtc_top
  import dbtc_pkg::*;
#(
  parameter int AXI_ADDR_W = 18    // holds four times the top index
) (
  input  wire logic                  core_clk_in,
  input  wire logic                  rst_n_in,
  // system state
  input  wire logic                  standby_in,
  // detection strobes
  input  wire dbtc_det_s             det_in,
  // axi4-lite write address
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr_in,
  input  wire logic                  s_axi_awvalid_in,
  output      logic                  s_axi_awready_out,
  // axi4-lite write data
  input  wire logic [31:0]           s_axi_wdata_in,
  input  wire logic [3:0]            s_axi_wstrb_in,
  input  wire logic                  s_axi_wvalid_in,
  output      logic                  s_axi_wready_out,
  // axi4-lite write response
  output      logic [1:0]            s_axi_bresp_out,
  output      logic                  s_axi_bvalid_out,
  input  wire logic                  s_axi_bready_in,
  // axi4-lite read address
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr_in,
  input  wire logic                  s_axi_arvalid_in,
  output      logic                  s_axi_arready_out,
  // axi4-lite read data
  output      logic [31:0]           s_axi_rdata_out,
  output      logic [1:0]            s_axi_rresp_out,
  output      logic                  s_axi_rvalid_out,
  input  wire logic                  s_axi_rready_in,
  // interrupt requests
  output      logic                  low_irq_out,
  output      logic                  high_irq_out,
  // operating mode, for observation
  output      dbtc_mode_e            mode_out
);

  // ---------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------
  // the index field is addr[17:2]; a narrower bus cannot reach it
  if (AXI_ADDR_W < 18) begin : g_addr_chk
    $error("dbtc_top: AXI_ADDR_W must be at least 18");
  end

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  // bus side
  logic                  aw_full_q, aw_full_d;  // address held
  logic                  w_full_q, w_full_d;    // data held
  logic [15:0]           aw_idx_q, aw_idx_d;    // held index
  logic [7:0]            w_byte_q, w_byte_d;    // held low byte
  logic                  w_lane_q, w_lane_d;    // lane 0 strobe
  logic                  bvalid_q, bvalid_d;
  logic [1:0]            bresp_q, bresp_d;
  logic                  rvalid_q, rvalid_d;
  logic [1:0]            rresp_q, rresp_d;
  logic [31:0]           rdata_q, rdata_d;
  logic                  do_write;              // write commits
  logic                  wr_hit;                // index mapped
  logic [15:0]           ar_idx;                // read index
  logic [7:0]            rd_byte;               // read mux out
  logic                  rd_hit;

  // software registers
  dbtc_ctrl_s            ctrl_q, ctrl_d;        // timer_control
  dbtc_isel_s            isel_q, isel_d;        // input select
  logic [7:0]            prr_q, prr_d;          // prescaler_match
  logic [7:0]            lmr_q, lmr_d;          // low_match_register
  logic [7:0]            hmr_q, hmr_d;          // high_match_register

  // counting state
  logic [7:0]            pre_q, pre_d;          // prescaler count
  logic [7:0]            low_q, low_d;          // low_counter
  logic [7:0]            high_q, high_d;        // high_counter
  logic [7:0]            lbuf_q, lbuf_d;        // low match buffer
  logic [7:0]            hbuf_q, hbuf_d;        // high match buffer
  logic [7:0]            lcap_q, lcap_d;        // low_capture_register
  logic [7:0]            hcap_q, hcap_d;        // high_capture_register

  // combinational strobes
  logic                  prr_wr;                // prescaler match write
  logic                  ctrl_wr;               // control write
  logic                  pre_match;             // prescaler pulse
  logic                  ext_event;             // selected event
  logic                  low_tick;              // low count clock
  logic                  high_tick;             // high count clock
  logic                  low_match;             // low match pulse
  logic                  high_match;            // high match pulse
  logic                  long_match;            // 16-bit match
  logic                  low_carry;             // low wraps into high
  logic                  low_cap_ev;            // low capture strobe
  logic                  high_cap_ev;           // high capture strobe
  logic                  low_pin_src;           // low pin source
  logic                  high_pin_src;          // high pin source

  // ---------------------------------------------------------------
  // bus: next values
  // ---------------------------------------------------------------
  // address and data are held independently so the master may offer
  // them in either order; the commit waits for both and for the
  // previous response to be gone, which gives the back-pressure
  always_comb begin
    aw_full_d = aw_full_q;
    w_full_d  = w_full_q;
    aw_idx_d  = aw_idx_q;
    w_byte_d  = w_byte_q;
    w_lane_d  = w_lane_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    do_write  = aw_full_q && w_full_q && !bvalid_q;
    // take the write address
    if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_full_d = 1'b1;
      aw_idx_d  = s_axi_awaddr_in[17:2];
    end
    // take the write data; only lane 0 carries a register
    if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_full_d = 1'b1;
      w_byte_d = s_axi_wdata_in[7:0];
      w_lane_d = s_axi_wstrb_in[0];
    end
    // commit and answer
    if (do_write) begin
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready_in) begin
      bvalid_d = 1'b0;
    end
    // read: data is registered one cycle after the address is taken
    if (s_axi_arvalid_in && s_axi_arready_out) begin
      rvalid_d = 1'b1;
      rresp_d  = rd_hit ? RESP_OKAY : RESP_SLVERR;
      rdata_d  = {24'h000000, rd_byte};
    end else if (rvalid_q && s_axi_rready_in) begin
      rvalid_d = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // bus: registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      aw_idx_q  <= 16'h0000;
      w_byte_q  <= RST_BYTE;
      w_lane_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      rvalid_q  <= 1'b0;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= 32'h00000000;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      aw_idx_q  <= aw_idx_d;
      w_byte_q  <= w_byte_d;
      w_lane_q  <= w_lane_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
    end
  end

  // handshake outputs
  assign s_axi_awready_out = !aw_full_q;
  assign s_axi_wready_out  = !w_full_q;
  assign s_axi_arready_out = !rvalid_q;
  assign s_axi_bvalid_out  = bvalid_q;
  assign s_axi_bresp_out   = bresp_q;
  assign s_axi_rvalid_out  = rvalid_q;
  assign s_axi_rresp_out   = rresp_q;
  assign s_axi_rdata_out   = rdata_q;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  // upper address bits above bit 17 are not decoded and alias
  always_comb begin
    case (aw_idx_q)
      IDX_TIMER_CONTROL, IDX_PRESCALER_MATCH, IDX_LOW_COUNTER,
      IDX_HIGH_COUNTER, IDX_LOW_MATCH, IDX_HIGH_MATCH,
      IDX_LOW_CAPTURE, IDX_HIGH_CAPTURE,
      IDX_INPUT_SELECT: wr_hit = 1'b1;
      default:          wr_hit = 1'b0;
    endcase
  end

  // read mux: plain selection, no side effect on any state
  assign ar_idx = s_axi_araddr_in[17:2];
  always_comb begin
    rd_hit  = 1'b1;
    rd_byte = 8'h00;
    case (ar_idx)
      IDX_TIMER_CONTROL:   rd_byte = ctrl_q;
      IDX_PRESCALER_MATCH: rd_byte = prr_q;
      IDX_LOW_COUNTER:     rd_byte = low_q;
      IDX_HIGH_COUNTER:    rd_byte = high_q;
      IDX_LOW_MATCH:       rd_byte = lmr_q;
      IDX_HIGH_MATCH:      rd_byte = hmr_q;
      IDX_LOW_CAPTURE:     rd_byte = lcap_q;
      IDX_HIGH_CAPTURE:    rd_byte = hcap_q;
      IDX_INPUT_SELECT:    rd_byte = isel_q;
      default:             rd_hit  = 1'b0;
    endcase
  end

  // write strobes that other logic needs to see
  assign ctrl_wr = do_write && w_lane_q && (aw_idx_q == IDX_TIMER_CONTROL);
  assign prr_wr  = do_write && w_lane_q
                   && (aw_idx_q == IDX_PRESCALER_MATCH);

  // ---------------------------------------------------------------
  // event selection
  // ---------------------------------------------------------------
  // detections are single-cycle strobes from the detectors; a level
  // detector simply strobes every cycle
  assign ext_event = isel_q.count_input_select_bit
                     ? det_in.ext_interrupt_d
                     : det_in.ext_interrupt_c;

  // an interrupt e assignment takes over the pin path
  assign low_pin_src = isel_q.low_cap_use_e ? det_in.ext_interrupt_e
                     : (isel_q.low_cap_pin_a ? det_in.ext_interrupt_a
                                             : det_in.ext_interrupt_c);
  assign high_pin_src = isel_q.high_cap_use_e ? det_in.ext_interrupt_e
                      : (isel_q.high_cap_pin_b ? det_in.ext_interrupt_b
                                               : det_in.ext_interrupt_d);

  assign low_cap_ev  = low_pin_src || det_in.port2_pin0
                       || det_in.port2_pin1;
  assign high_cap_ev = high_pin_src || det_in.port2_pin0
                       || det_in.port2_pin1;

  // ---------------------------------------------------------------
  // count clocks and match pulses
  // ---------------------------------------------------------------
  // mode is simply the two control bits side by side
  assign mode_out = dbtc_mode_e'({ctrl_q.sixteen_bit_mode_bit,
                                  ctrl_q.external_clock_select_bit});

  // prescaler pulse; none while the standby freezes it
  assign pre_match = !standby_in && (pre_q == prr_q);

  // low clock: prescaler in modes 0/2, events in modes 1/3
  assign low_tick = ctrl_q.external_clock_select_bit
                    ? ext_event : pre_match;

  // chained match needs all sixteen bits and both halves running
  assign long_match = ctrl_q.low_run_bit && ctrl_q.high_run_bit
                      && low_tick
                      && ({high_q, low_q} == {hbuf_q, lbuf_q});

  // in 16-bit mode the low half wraps at its top into the high half
  assign low_carry = ctrl_q.low_run_bit && low_tick && (low_q == 8'hFF);

  // high clock: prescaler, or the low half's wrap when chained
  assign high_tick = ctrl_q.sixteen_bit_mode_bit
                     ? low_carry : pre_match;

  always_comb begin
    if (ctrl_q.sixteen_bit_mode_bit) begin
      low_match  = long_match;
      high_match = long_match;
    end else begin
      low_match  = ctrl_q.low_run_bit && low_tick
                   && (low_q == lbuf_q);
      high_match = ctrl_q.high_run_bit && high_tick
                   && (high_q == hbuf_q);
    end
  end

  // ---------------------------------------------------------------
  // registers and counters: next values
  // ---------------------------------------------------------------
  always_comb begin
    ctrl_d = ctrl_q;
    isel_d = isel_q;
    prr_d  = prr_q;
    lmr_d  = lmr_q;
    hmr_d  = hmr_q;
    // software writes, low byte lane only
    if (do_write && w_lane_q) begin
      case (aw_idx_q)
        IDX_TIMER_CONTROL:   ctrl_d = w_byte_q;
        IDX_PRESCALER_MATCH: prr_d  = w_byte_q;
        IDX_LOW_MATCH:       lmr_d  = w_byte_q;
        IDX_HIGH_MATCH:      hmr_d  = w_byte_q;
        IDX_INPUT_SELECT:    isel_d = {3'h0, w_byte_q[4:0]};
        default:             ctrl_d = ctrl_q;
      endcase
    end
    // flags: a match in the cycle of a clearing write still sets
    if (low_match) begin
      ctrl_d.low_match_flag = 1'b1;
    end
    if (high_match) begin
      ctrl_d.high_match_flag = 1'b1;
    end

    // prescaler: frozen in standby, restarts on pulse or write
    if (prr_wr || pre_match) begin
      pre_d = 8'h00;
    end else if (standby_in) begin
      pre_d = pre_q;
    end else begin
      pre_d = pre_q + 8'h01;
    end

    // low half
    if (!ctrl_q.low_run_bit) begin
      low_d = 8'h00;
    end else if (low_match) begin
      low_d = 8'h00;
    end else if (low_tick) begin
      low_d = low_q + 8'h01;
    end else begin
      low_d = low_q;
    end

    // high half
    if (!ctrl_q.high_run_bit) begin
      high_d = 8'h00;
    end else if (high_match) begin
      high_d = 8'h00;
    end else if (high_tick) begin
      high_d = high_q + 8'h01;
    end else begin
      high_d = high_q;
    end

    // match buffers: follow the register while stopped, else reload
    // only at a match so a new value never cuts a period short
    if (!ctrl_q.low_run_bit || low_match) begin
      lbuf_d = lmr_q;
    end else begin
      lbuf_d = lbuf_q;
    end
    if (!ctrl_q.high_run_bit || high_match) begin
      hbuf_d = hmr_q;
    end else begin
      hbuf_d = hbuf_q;
    end

    // captures hold until the next capture strobe
    lcap_d = lcap_q;
    hcap_d = hcap_q;
    if (ctrl_q.sixteen_bit_mode_bit) begin
      if (high_cap_ev) begin
        lcap_d = low_q;
        hcap_d = high_q;
      end
    end else begin
      if (low_cap_ev) begin
        lcap_d = low_q;
      end
      if (high_cap_ev) begin
        hcap_d = high_q;
      end
    end
  end

  // ---------------------------------------------------------------
  // registers and counters: registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      ctrl_q <= RST_BYTE;
      isel_q <= RST_BYTE;
      prr_q  <= RST_BYTE;
      lmr_q  <= RST_BYTE;
      hmr_q  <= RST_BYTE;
      pre_q  <= RST_BYTE;
      low_q  <= RST_BYTE;
      high_q <= RST_BYTE;
      lbuf_q <= RST_BYTE;
      hbuf_q <= RST_BYTE;
      lcap_q <= RST_BYTE;
      hcap_q <= RST_BYTE;
    end else begin
      ctrl_q <= ctrl_d;
      isel_q <= isel_d;
      prr_q  <= prr_d;
      lmr_q  <= lmr_d;
      hmr_q  <= hmr_d;
      pre_q  <= pre_d;
      low_q  <= low_d;
      high_q <= high_d;
      lbuf_q <= lbuf_d;
      hbuf_q <= hbuf_d;
      lcap_q <= lcap_d;
      hcap_q <= hcap_d;
    end
  end

  // ---------------------------------------------------------------
  // interrupt requests
  // ---------------------------------------------------------------
  // level requests from flag and enable flops; the flag is set once
  // per period and stays until software clears it
  assign low_irq_out  = ctrl_q.low_match_flag
                        && ctrl_q.low_interrupt_enable;
  assign high_irq_out = ctrl_q.high_match_flag
                        && ctrl_q.high_interrupt_enable;

endmodule // dbtc_top

// [dbtc_pkg.sv]
// dbtc_pkg: constants, register map and carriers of the dual byte timer.
// assumes an AXI4-Lite master and 8-bit registers on one-word slots.
//
// Behaviour
// - prescaler steps each cycle, stops in standby
// - prescaler pulses when count equals match value
// - prescaler restarts on pulse or match write
// - low counter counts only when run set
// - low clock: prescaler pulse or external event
// - high counter counts only when run set
// - high clock: prescaler pulse or low carry
// - half cleared when stopped or on match
// - match against buffers, sixteen bits chained
// - mode 0: two prescaler timers
// - mode 1: low counts events, high timer
// - mode 2: one sixteen bit prescaler timer
// - mode 3: one sixteen bit event counter
// - byte modes: low sources capture low counter
// - byte modes: high sources capture high counter
// - sixteen bit: high sources capture both halves
// - enabled half requests interrupt once per period
// - count source: interrupt d or interrupt c
// - interrupt e capture masks the pin source
// - mode from sixteen bit and external bits
// - buffer tracks register stopped, reloads on match
// - match sets flag, software clears it
// - sixteen bit: both flags set together
package dbtc_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [15:0] IDX_TIMER_CONTROL   = 16'hFE10;
  localparam logic [15:0] IDX_PRESCALER_MATCH = 16'hFE11;
  localparam logic [15:0] IDX_LOW_COUNTER     = 16'hFE12;
  localparam logic [15:0] IDX_HIGH_COUNTER    = 16'hFE13;
  localparam logic [15:0] IDX_LOW_MATCH       = 16'hFE14;
  localparam logic [15:0] IDX_HIGH_MATCH      = 16'hFE15;
  localparam logic [15:0] IDX_LOW_CAPTURE     = 16'hFE16;
  localparam logic [15:0] IDX_HIGH_CAPTURE    = 16'hFE17;
  localparam logic [15:0] IDX_INPUT_SELECT    = 16'hFE18;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;

  // ---------------------------------------------------------------
  // bus answers
  // ---------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // timing: prescaler step is one cycle clock of 5 ns
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS  = 5000;
  localparam int PRE_STEP_PS    = 5000;
  localparam int PRE_STEP_CYC   = PRE_STEP_PS / CLK_PERIOD_PS;

  // ---------------------------------------------------------------
  // carriers: field order equals bit order, msb first
  // ---------------------------------------------------------------
  typedef struct packed {
    logic high_run_bit;               // bit 7
    logic low_run_bit;                // bit 6
    logic sixteen_bit_mode_bit;       // bit 5
    logic external_clock_select_bit;  // bit 4
    logic high_match_flag;            // bit 3
    logic high_interrupt_enable;      // bit 2
    logic low_match_flag;             // bit 1
    logic low_interrupt_enable;       // bit 0
  } dbtc_ctrl_s;

  typedef struct packed {
    logic [2:0] unused;               // bits 7..5, read zero
    logic       high_cap_use_e;       // bit 4
    logic       low_cap_use_e;        // bit 3
    logic       high_cap_pin_b;       // bit 2: 1 int b, 0 int d
    logic       low_cap_pin_a;        // bit 1: 1 int a, 0 int c
    logic       count_input_select_bit; // bit 0: 1 int d, 0 int c
  } dbtc_isel_s;

  // detection strobes from the pin detectors
  typedef struct packed {
    logic ext_interrupt_a;
    logic ext_interrupt_b;
    logic ext_interrupt_c;
    logic ext_interrupt_d;
    logic ext_interrupt_e;
    logic port2_pin0;
    logic port2_pin1;
  } dbtc_det_s;

  // operating mode, named for readability
  typedef enum logic [1:0] {
    DBTC_MODE_TWO_TIMERS  = 2'b00,
    DBTC_MODE_TIMER_EVENT = 2'b01,
    DBTC_MODE_LONG_TIMER  = 2'b10,
    DBTC_MODE_LONG_EVENT  = 2'b11
  } dbtc_mode_e;

endpackage : dbtc_pkg

// [dbtc_asserts.sv]
// dbtc_asserts: port checks of dbtc_top, bound at the foot.
// assumes one clock and the synchronous active low reset.
module dbtc_asserts
  import dbtc_pkg::*;
(
  input wire logic       core_clk_in,
  input wire logic       rst_n_in,
  input wire logic       s_axi_awvalid_in,
  input wire logic       s_axi_awready_out,
  input wire logic       s_axi_wvalid_in,
  input wire logic       s_axi_wready_out,
  input wire logic       s_axi_bvalid_out,
  input wire logic       s_axi_arvalid_in,
  input wire logic       s_axi_arready_out,
  input wire logic       s_axi_rvalid_out,
  input wire logic       low_irq_out,
  input wire logic       high_irq_out,
  input wire dbtc_mode_e mode_out
);
  timeunit 1ns / 1ps;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  // irq requests only fall and mode only moves at a write commit, never by themselves
  AST_LOW_HOLD: assert property ($fell(low_irq_out)
    |-> s_axi_bvalid_out) else $error("low irq fell alone");
  AST_HIGH_HOLD: assert property ($fell(high_irq_out)
    |-> s_axi_bvalid_out) else $error("high irq fell alone");
  AST_MODE_HOLD: assert property (!$stable(mode_out)
    |-> s_axi_bvalid_out) else $error("mode moved alone");
  AST_RESET: assert property (disable iff (1'b0) !rst_n_in
    |=> !low_irq_out && !high_irq_out) else $error("irq after reset");
  AST_RD_LAT: assert property (s_axi_arvalid_in && s_axi_arready_out
    |=> s_axi_rvalid_out) else $error("read answer late");
  AST_AR_BUSY: assert property (s_axi_rvalid_out
    |-> !s_axi_arready_out) else $error("read taken twice");
  AST_AW_BUSY: assert property (s_axi_awvalid_in && s_axi_awready_out
    |=> !s_axi_awready_out) else $error("address taken twice");
  AST_WR_LAT: assert property (s_axi_awvalid_in && s_axi_awready_out
    && s_axi_wvalid_in && s_axi_wready_out && !s_axi_bvalid_out
    |-> ##2 s_axi_bvalid_out) else $error("write answer late");
  cover property (mode_out[1] && $rose(low_irq_out) && $rose(high_irq_out));
  cover property (mode_out == DBTC_MODE_TIMER_EVENT && $rose(low_irq_out));
  cover property (mode_out == DBTC_MODE_TWO_TIMERS && $rose(high_irq_out));
endmodule // dbtc_asserts

bind dbtc_top dbtc_asserts i_dbtc_asserts (.core_clk_in, .rst_n_in,
  .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out,
  .s_axi_bvalid_out, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rvalid_out,
  .low_irq_out, .high_irq_out, .mode_out);

// [dbtc_pins.sv]
// dbtc_pins: pin detector model, requests become detection strobes.
// assumes the bench holds each request for exactly one cycle.
module dbtc_pins
  import dbtc_pkg::*;
(
  input  wire logic      core_clk_in,
  input  wire logic      rst_n_in,
  input  wire dbtc_det_s req_in,
  output      dbtc_det_s det_out
);
  timeunit 1ns / 1ps;
  // registered, so each strobe is clean and one cycle long
  always_ff @(posedge core_clk_in) begin
    det_out <= rst_n_in ? req_in : dbtc_det_s'(7'h00);
  end
endmodule // dbtc_pins

// [tb.sv]
// tb: random and corner tests of dbtc_top over axi4-lite.
// assumes dbtc_pins stands between the bench and the detectors.
module tb
  import dbtc_pkg::*;
;
  timeunit 1ns / 1ps;
  logic        clk = 1'b0, rst_n = 1'b0, ev_on = 1'b0, lirq, hirq;
  logic        awv = 1'b0, wv = 1'b0, bre = 1'b1, arv = 1'b0, rre = 1'b1;
  logic        stby = 1'b0;  // deep standby request
  logic        awr, wrd, arr, bv, rv;
  logic [17:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [1:0]  rresp, bresp;
  dbtc_det_s   man = '0, req = '0, det;
  dbtc_mode_e  mode;
  int          cyc = 0, fail_count = 0, comparisons = 0;
  always #2.5 clk = ~clk;
  // background events on int c every fourth cycle, plus one-shots
  always @(posedge clk) begin
    cyc <= cyc + 1;
    req <= man | {2'b00, ev_on && cyc % 4 == 0, 4'h0};
  end
  dbtc_top i_dbtc_top (.core_clk_in(clk), .rst_n_in(rst_n),
    .standby_in(stby), .det_in(det), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrd),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv), .s_axi_bready_in(bre),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arr), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv), .s_axi_rready_in(rre),
    .low_irq_out(lirq), .high_irq_out(hirq), .mode_out(mode));
  dbtc_pins i_dbtc_pins (.core_clk_in(clk), .rst_n_in(rst_n), .req_in(req),
    .det_out(det));
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // address and data offered together, each dropped once taken;
  // bready and rready stay high, so answers are taken at once and
  // only the watchdog ends a wait that never gets its answer
  task automatic wr(logic [15:0] i, logic [7:0] d);
    {awaddr, wdata, awv, wv} <= {i, 2'b00, 24'h0, d, 2'b11};
    do begin
      @(posedge clk);
      if (awr && awv) awv <= 1'b0;
      if (wrd && wv) wv <= 1'b0;
    end while (!bv);
    chk("write resp", {30'h0, RESP_OKAY}, {30'h0, bresp});
  endtask
  task automatic rc(logic [15:0] i, logic [7:0] e, logic [1:0] er = RESP_OKAY);
    {araddr, arv} <= {i, 2'b00, 1'b1};
    do begin
      @(posedge clk);
      if (arr && arv) arv <= 1'b0;
    end while (!rv);
    chk("read data", {24'h0, e}, rdata);
    chk("read resp", {30'h0, er}, {30'h0, rresp});
  endtask
  task automatic pulse(dbtc_det_s m);
    man <= m;
    @(posedge clk);
    man <= '0;
    @(posedge clk);
  endtask
  // expected irq period in clocks: ticks per period times tick spacing
  function automatic int period(int m, int p, int l, int h);
    return (m > 1 ? h * 256 + l + 1 : l + 1) * (m[0] ? 4 : p + 1);
  endfunction
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #100us;
    fail_count++;
    print_verdict();
  end
  initial begin
    logic [7:0] p, lr, hr, c;
    int t0, n, k;
    void'($urandom(43215));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) rc(IDX_TIMER_CONTROL + 16'(i), 8'h00);
    wr(IDX_LOW_COUNTER, 8'h5A);
    rc(IDX_LOW_COUNTER, 8'h00);
    rc(16'hFE20, 8'h00, RESP_SLVERR);
    // every mode: time two irq rises, flags cleared between them
    for (int m = 0; m < 4; m++) begin
      p = 8'($urandom_range(6, 3));
      lr = 8'($urandom_range(6, 3));
      hr = m > 1 ? 8'h01 : lr;
      c = {2'b11, 2'(m), 4'h5};
      ev_on <= m[0];
      wr(IDX_PRESCALER_MATCH, p);
      wr(IDX_LOW_MATCH, lr);
      wr(IDX_HIGH_MATCH, hr);
      wr(IDX_TIMER_CONTROL, c);
      chk("mode", 32'(m), {30'h0, mode});
      for (int w = 0; w < 2; w++) begin
        for (k = 0; lirq !== 1'b1 && k < 4000; k++) @(posedge clk);
        n = cyc - t0;
        t0 = cyc;
        if (w == 0) wr(IDX_TIMER_CONTROL, c);
      end
      chk("period", period(m, p, lr, hr), n);
      if (m > 1) chk("high irq", 32'h1, {31'h0, hirq});
      wr(IDX_TIMER_CONTROL, 8'h00);
    end
    // count on int d only, then capture on port2 pin0
    ev_on <= 1'b0;
    wr(IDX_INPUT_SELECT, 8'h01);
    wr(IDX_LOW_MATCH, 8'hFF);
    wr(IDX_TIMER_CONTROL, 8'h50);
    n = $urandom_range(20, 1);
    repeat (n) pulse(7'h08);
    pulse(7'h10);
    pulse(7'h02);
    rc(IDX_LOW_CAPTURE, 8'(n));
    rc(IDX_LOW_COUNTER, 8'(n));
    wr(IDX_TIMER_CONTROL, 8'h10);
    pulse(7'h08);
    rc(IDX_LOW_COUNTER, 8'h00);
    rc(IDX_LOW_CAPTURE, 8'(n));
    // standby freezes the prescaler, so a running low half stays put
    wr(IDX_PRESCALER_MATCH, 8'h00);
    stby <= 1'b1;
    wr(IDX_TIMER_CONTROL, 8'h40);
    repeat (9) @(posedge clk);
    rc(IDX_LOW_COUNTER, 8'h00);
    print_verdict();
  end
endmodule // tb
